// File: verilog/logger_pkg.sv
package logger_pkg;
  localparam logic [7:0]  OP_STOP   = 8'h33;
  localparam logic [7:0]  OP_RDMEM  = 8'h69;
  localparam logic [7:0]  OP_COPY   = 8'h99;
  localparam logic [7:0]  OP_RDSCR  = 8'haa;
  localparam logic [7:0]  DUMMY_B   = 8'hff;
  localparam logic [7:0]  IDLE_B    = 8'hff;
  localparam logic [7:0]  ALT_B     = 8'haa;
  localparam logic [15:0] STAT_ADDR = 16'h0215;
  localparam int          MIP_BIT   = 1;
  localparam int          ALARM_WAIT_FLAG_BIT  = 4;
  localparam logic [15:0] CRC_POLY  = 16'ha001;
  localparam logic        MIP_RST   = 1'b0;
  localparam logic        ALARM_WAIT_FLAG_RST  = 1'b0;
  localparam int          CLK_NS    = 25;
  localparam int          LOW_STD_NS = 120000;
  localparam int          LOW_OD_NS  = 12000;
  localparam int          LOW_STD_CYC = LOW_STD_NS / CLK_NS;
  localparam int          LOW_OD_CYC  = LOW_OD_NS / CLK_NS;
  localparam int          SAMPLE_MS   = 666;
  localparam int          FIFO_W      = 8;
  localparam int          FIFO_D      = 8;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_t;

  typedef enum logic [3:0] {
    S_IDLE   = 4'h0,
    S_CMD    = 4'h1,
    S_ADDR   = 4'h2,
    S_AUTH   = 4'h3,
    S_PW     = 4'h4,
    S_DUMMY  = 4'h5,
    S_SEND   = 4'h6,
    S_CRC    = 4'h7,
    S_ONES   = 4'h8,
    S_ALT    = 4'h9,
    S_SILENT = 4'ha
  } cmd_state_t;
endpackage

// File: verilog/byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  // fill side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // drain side
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } fifo_st_t;

  fifo_st_t q;
  fifo_st_t d;
  logic     wr;
  logic     rd;

  assign in_ready_o  = q.cnt != (AW+1)'(D);
  assign out_valid_o = q.cnt != '0;
  assign out_data_o  = q.mem[q.rp];

  always_comb begin
    d  = q;
    wr = in_valid_i && in_ready_o;
    rd = out_valid_o && out_ready_i;
    if (wr) begin
      d.mem[q.wp] = in_data_i;
      d.wp        = q.wp + 1'b1;
    end
    if (rd) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(wr) - (AW+1)'(rd);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// File: verilog/mission_stop_access_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module mission_stop_access_arbiter #(
  parameter int LOW_STD_CYC = logger_pkg::LOW_STD_CYC
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  // bus line, open drain
  input  wire logic              line_i,
  output logic                   line_o,
  output logic                   line_oe_o,
  input  wire logic              overdrive_i,
  // bit-slot layer
  input  wire logic              rom_done_i,
  input  wire logger_pkg::byte_t rx_i,
  input  wire logic              drive_low_i,
  output logic                   tx_valid_o,
  output logic [7:0]             tx_data_o,
  input  wire logic              tx_ready_i,
  // mission and sampler
  input  wire logic              sample_busy_i,
  input  wire logic              mission_start_i,
  input  wire logic              alarm_wait_flag_set_i,
  input  wire logic              alarm_wait_flag_clr_i,
  output logic                   mip_o,
  output logic                   alarm_wait_flag_o,
  output logic [7:0]             status_o,
  // passwords and copy check
  input  wire logic              pw_en_i,
  input  wire logic [63:0]       full_pw_i,
  input  wire logic [63:0]       read_pw_i,
  input  wire logic [23:0]       auth_i,
  input  wire logic              copy_reg_page_i,
  // memory port
  output logic [15:0]            mem_addr_o,
  output logic                   mem_rd_o,
  output logic                   scr_sel_o,
  input  wire logic [7:0]        mem_rdata_i,
  output logic                   reg_wr_en_o,
  output logic                   mem_wr_en_o,
  output logic                   copy_go_o
);
  localparam logic [12:0] STD_LIM = 13'(LOW_STD_CYC);
  localparam logic [12:0] OD_LIM  = 13'(logger_pkg::LOW_OD_CYC);

  typedef struct packed {
    logger_pkg::cmd_state_t st;
    logic [1:0]             ln;
    logic [12:0]            low;
    logic [3:0]             cnt;
    logic [7:0]             opc;
    logic [63:0]            pw;
    logic [23:0]            auth;
    logic [15:0]            addr;
    logic [15:0]            crc;
    logic                   hit;
    logic                   scr;
    logic                   mission_active_flag;
    logic                   alarm_wait_flag;
    logic                   go;
  } arb_st_t;

  arb_st_t     q;
  arb_st_t     d;
  logic        push;
  logic [7:0]  pbyte;
  logic        in_rdy;
  logic [12:0] lim;
  logic        bus_rst;
  logic        pw_ok;
  logic        busy;
  logic [63:0] pw_n;
  logic [7:0]  status;

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ logger_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // status byte and static outputs

  always_comb begin
    status                       = 8'h00;
    status[logger_pkg::MIP_BIT]  = q.mission_active_flag;
    status[logger_pkg::ALARM_WAIT_FLAG_BIT] = q.alarm_wait_flag;
  end

  assign status_o    = status;
  assign mip_o       = q.mission_active_flag;
  assign alarm_wait_flag_o      = q.alarm_wait_flag;
  assign line_o      = 1'b0;
  // drive only inside a slot the master already opened
  assign line_oe_o   = drive_low_i && !q.ln[1] && q.st != logger_pkg::S_SILENT;
  assign mem_addr_o  = q.addr;
  assign mem_rd_o    = q.st == logger_pkg::S_SEND;
  assign scr_sel_o   = q.scr;
  assign reg_wr_en_o = !q.mission_active_flag;
  assign busy        = sample_busy_i && (q.mission_active_flag || q.alarm_wait_flag);
  assign mem_wr_en_o = !sample_busy_i;
  assign copy_go_o   = q.go;

  ////////////////////////////////////////////////////////////////////////
  // command sequencer

  always_comb begin
    d       = q;
    d.go    = 1'b0;
    push    = 1'b0;
    pbyte   = logger_pkg::IDLE_B;
    d.ln    = {q.ln[0], line_i};
    lim     = overdrive_i ? OD_LIM : STD_LIM;
    bus_rst = !q.ln[1] && q.low == lim;
    pw_n    = {rx_i.data, q.pw[63:8]};
    pw_ok   = !pw_en_i || pw_n == full_pw_i ||
              (q.opc == logger_pkg::OP_RDMEM && pw_n == read_pw_i);
    if (q.ln[1]) begin
      d.low = '0;
    end else if (q.low != lim) begin
      d.low = q.low + 13'h0001;
    end
    // a long sample keeps this sticky until the next command starts (rom_done_i in S_IDLE)
    if (busy && q.st != logger_pkg::S_IDLE) begin
      d.hit = 1'b1;
    end
    if (alarm_wait_flag_clr_i) begin
      d.alarm_wait_flag = 1'b0;
    end
    if (alarm_wait_flag_set_i) begin
      d.alarm_wait_flag = 1'b1;
    end
    unique case (q.st)
      logger_pkg::S_IDLE: begin
        if (rom_done_i) begin
          d.st  = logger_pkg::S_CMD;
          d.hit = 1'b0;
          d.cnt = '0;
          d.scr = 1'b0;
        end
      end
      logger_pkg::S_CMD: begin
        if (rx_i.valid) begin
          d.opc = rx_i.data;
          d.crc = crc_upd(16'h0000, rx_i.data);
          d.cnt = '0;
          unique case (rx_i.data)
            logger_pkg::OP_STOP:  d.st = logger_pkg::S_PW;
            logger_pkg::OP_RDMEM: d.st = logger_pkg::S_ADDR;
            logger_pkg::OP_COPY:  d.st = logger_pkg::S_AUTH;
            logger_pkg::OP_RDSCR: begin
              d.st   = logger_pkg::S_SEND;
              d.scr  = 1'b1;
              d.addr = '0;
            end
            default: d.st = logger_pkg::S_SILENT;
          endcase
        end
      end
      logger_pkg::S_ADDR: begin
        if (rx_i.valid) begin
          d.addr = {rx_i.data, q.addr[15:8]};
          d.crc  = crc_upd(q.crc, rx_i.data);
          d.cnt  = q.cnt + 4'h1;
          if (q.cnt == 4'h1) begin
            d.st  = logger_pkg::S_PW;
            d.cnt = '0;
          end
        end
      end
      logger_pkg::S_AUTH: begin
        if (rx_i.valid) begin
          d.auth = {rx_i.data, q.auth[23:8]};
          d.cnt  = q.cnt + 4'h1;
          if (q.cnt == 4'h2) begin
            d.st  = logger_pkg::S_PW;
            d.cnt = '0;
          end
        end
      end
      logger_pkg::S_PW: begin
        if (rx_i.valid) begin
          d.pw  = pw_n;
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == 4'h7) begin
            if (q.opc == logger_pkg::OP_STOP) begin
              d.st = logger_pkg::S_DUMMY;
            end else if (!pw_ok) begin
              d.st = logger_pkg::S_SILENT;
            end else if (q.opc == logger_pkg::OP_RDMEM) begin
              d.st = logger_pkg::S_SEND;
            end else if (d.hit || q.auth != auth_i ||
                         (copy_reg_page_i && q.mission_active_flag)) begin
              d.st = logger_pkg::S_SILENT;
            end else begin
              d.go = 1'b1;
              d.st = logger_pkg::S_ALT;
            end
          end
        end
      end
      logger_pkg::S_DUMMY: begin
        if (rx_i.valid) begin
          d.st = logger_pkg::S_SILENT;
          if (rx_i.data == logger_pkg::DUMMY_B && q.mission_active_flag && !d.hit &&
              (!pw_en_i || q.pw == full_pw_i)) begin
            d.mission_active_flag = 1'b0;
            // alarm wait is deliberately left as it is
            d.alarm_wait_flag = d.alarm_wait_flag;
          end
          // an interfered stop keeps the mission flag set
          if (d.hit) begin
            d.mission_active_flag = q.mission_active_flag;
          end
        end
      end
      logger_pkg::S_SEND: begin
        if (in_rdy) begin
          push  = 1'b1;
          pbyte = q.addr == logger_pkg::STAT_ADDR ? status : mem_rdata_i;
          if (d.hit) begin
            pbyte = logger_pkg::IDLE_B;
          end
          d.crc  = crc_upd(q.crc, pbyte);
          d.addr = q.addr + 16'h0001;
          if (q.addr[4:0] == 5'h1f) begin
            d.st  = logger_pkg::S_CRC;
            d.cnt = '0;
          end
        end
      end
      logger_pkg::S_CRC: begin
        if (in_rdy) begin
          push  = 1'b1;
          pbyte = q.cnt == 4'h0 ? ~q.crc[7:0] : ~q.crc[15:8];
          if (d.hit) begin
            pbyte = logger_pkg::IDLE_B;
          end
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == 4'h1) begin
            d.crc = '0;
            d.st  = q.scr ? logger_pkg::S_ONES : logger_pkg::S_SEND;
          end
        end
      end
      logger_pkg::S_ONES: begin
        push  = in_rdy;
        pbyte = logger_pkg::IDLE_B;
      end
      logger_pkg::S_ALT: begin
        push  = in_rdy;
        pbyte = logger_pkg::ALT_B;
      end
      logger_pkg::S_SILENT: begin
        d.st = logger_pkg::S_SILENT;
      end
      default: d.st = logger_pkg::S_IDLE;
    endcase
    // a new mission wins over a stop in the same cycle
    if (mission_start_i) begin
      d.mission_active_flag = 1'b1;
    end
    // reset by the line ends every transfer at once
    if (bus_rst) begin
      d.st  = logger_pkg::S_IDLE;
      d.scr = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q      <= '0;
      q.ln   <= 2'h3;
      q.mission_active_flag  <= logger_pkg::MIP_RST;
      q.alarm_wait_flag <= logger_pkg::ALARM_WAIT_FLAG_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // response buffer; a slow drain stalls the sender

  byte_fifo #(
    .W (logger_pkg::FIFO_W),
    .D (logger_pkg::FIFO_D)
  ) u_tx_fifo (
    .clk_i       (clk_i),
    .srst_i      (srst_i || bus_rst),
    .in_valid_i  (push),
    .in_data_i   (pbyte),
    .in_ready_o  (in_rdy),
    .out_valid_o (tx_valid_o),
    .out_data_o  (tx_data_o),
    .out_ready_i (tx_ready_i)
  );
endmodule
`default_nettype wire

// File: dv/access_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module access_monitor #(
  parameter int LOW_STD_CYC = 40
) (
  // clock and reset
  input wire logic              clk_i,
  input wire logic              srst_i,
  // bus side
  input wire logic              line_i,
  input wire logic              line_o,
  input wire logic              rom_done_i,
  input wire logger_pkg::byte_t rx_i,
  input wire logic              tx_valid_o,
  input wire logic [7:0]        tx_data_o,
  input wire logic              tx_ready_i,
  // mission, sampler, memory
  input wire logic              sample_busy_i,
  input wire logic              alarm_wait_flag_set_i,
  input wire logic              alarm_wait_flag_clr_i,
  input wire logic              mip_o,
  input wire logic              alarm_wait_flag_o,
  input wire logic              reg_wr_en_o,
  input wire logic              mem_wr_en_o,
  input wire logic              copy_go_o
);
  localparam int LIM = LOW_STD_CYC + 6;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////
  // seen: sampling hit since the command began; early: it was already running then
  logic        busy;
  logic        seen_q;
  logic        early_q;
  logic [15:0] low_q;
  assign busy = sample_busy_i & (mip_o | alarm_wait_flag_o);
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      seen_q  <= 1'b0;
      early_q <= 1'b0;
      low_q   <= 16'h0;
    end else begin
      seen_q  <= rom_done_i ? busy : (seen_q | busy);
      early_q <= rom_done_i ? busy : early_q;
      // saturates so a very long low never wraps to zero
      low_q   <= line_i ? 16'h0 : low_q + {15'h0, low_q != 16'hffff};
    end
  end
  ////////////////////////////////////////
  sequence s_dummy; rx_i.valid && rx_i.data == logger_pkg::DUMMY_B; endsequence
  sequence s_pop; tx_valid_o && tx_ready_i; endsequence
  property p_open_drain; line_o == 1'b0; endproperty
  property p_stop_only; mip_o && !(rx_i.valid && rx_i.data == 8'hff) |=> mip_o; endproperty
  property p_keep_wait;
    s_dummy ##1 $fell(mip_o) |-> $stable(alarm_wait_flag_o) || $past(alarm_wait_flag_set_i) || $past(alarm_wait_flag_clr_i);
  endproperty
  property p_no_clear_busy; seen_q |=> !$fell(mip_o); endproperty
  property p_copy_once; copy_go_o |-> !seen_q ##1 !copy_go_o; endproperty
  property p_reg_lock; reg_wr_en_o == !mip_o; endproperty
  property p_mem_block; mem_wr_en_o == !sample_busy_i; endproperty
  property p_line_reset; low_q > LIM |-> !tx_valid_o; endproperty
  property p_ones; early_q ##0 s_pop |-> tx_data_o == 8'hff; endproperty
  property p_wait_flag; $past(alarm_wait_flag_set_i) |-> alarm_wait_flag_o; endproperty
  a_open_drain: assert property (p_open_drain) else $error("line data not low");
  a_stop_only: assert property (p_stop_only) else $error("mission flag lost");
  a_keep_wait: assert property (p_keep_wait) else $error("wait flag moved on stop");
  a_no_clear_busy: assert property (p_no_clear_busy) else $error("stop under sampling");
  a_copy_once: assert property (p_copy_once) else $error("bad copy commit");
  a_reg_lock: assert property (p_reg_lock) else $error("page lock wrong");
  a_mem_block: assert property (p_mem_block) else $error("memory not blocked");
  a_line_reset: assert property (p_line_reset) else $error("long low kept data");
  a_ones: assert property (p_ones) else $error("interfered byte not ones");
  a_wait_flag: assert property (p_wait_flag) else $error("wait flag not set");
endmodule
bind mission_stop_access_arbiter access_monitor #(.LOW_STD_CYC(LOW_STD_CYC)) access_monitor_inst (
  .clk_i(clk_i), .srst_i(srst_i), .line_i(line_i), .line_o(line_o), .rom_done_i(rom_done_i),
  .rx_i(rx_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
  .sample_busy_i(sample_busy_i), .alarm_wait_flag_set_i(alarm_wait_flag_set_i), .alarm_wait_flag_clr_i(alarm_wait_flag_clr_i),
  .mip_o(mip_o), .alarm_wait_flag_o(alarm_wait_flag_o), .reg_wr_en_o(reg_wr_en_o), .mem_wr_en_o(mem_wr_en_o),
  .copy_go_o(copy_go_o));
`default_nettype wire

// File: dv/bus_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
  // clock
  input  wire logic         clk_i,
  // device side
  input  wire logic         line_oe_i,
  input  wire logic         tx_valid_i,
  input  wire logic [7:0]   tx_data_i,
  // master side
  output logic              line_o,
  output logger_pkg::byte_t rx_o,
  output logic              tx_ready_o
);
  logic pull_q = 1'b0;
  // wired line with pull-up: high whenever nobody pulls
  assign line_o = !(pull_q || line_oe_i);
  initial begin
    rx_o = '0;
    tx_ready_o = 1'b0;
  end
  // the master opens every slot; one byte per call keeps well under the rate cap
  task automatic send(input logic [7:0] b);
    @(posedge clk_i);
    rx_o <= {1'b1, b};
    @(posedge clk_i);
    rx_o <= '0;
  endtask
  // reset pulse, then back to idle high
  task automatic bus_reset(input int n);
    @(posedge clk_i);
    pull_q <= 1'b1;
    repeat (n) @(posedge clk_i);
    pull_q <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // stalls first, then pops one byte; ok stays 0 if the device keeps quiet
  task automatic fetch(input int stall, input int lim, output logic [7:0] b, output bit ok);
    ok = 1'b0;
    b = 8'h00;
    repeat (stall) @(posedge clk_i);
    for (int i = 0; i < lim && !ok; i++) begin
      @(posedge clk_i);
      #1;
      if (tx_valid_i === 1'b1) begin
        ok = 1'b1;
        b = tx_data_i;
        tx_ready_o <= 1'b1;
      end
    end
    if (ok) begin
      @(posedge clk_i);
      #1;
      tx_ready_o <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// File: dv/mission_stop_access_arbiter_test.sv
`timescale 1ns/1ps
`default_nettype none
module mission_stop_access_arbiter_test;
  localparam int          LOW  = 40;
  localparam logic [63:0] PW   = 64'h0123456789abcdef;
  localparam logic [23:0] AUTH = 24'h1f0215;
  localparam logic [7:0]  ST   = (8'h01 << logger_pkg::MIP_BIT) | (8'h01 << logger_pkg::ALARM_WAIT_FLAG_BIT);
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic              rom_done = 1'b0;
  logic              busy = 1'b0;
  logic              mstart = 1'b0;
  logic              wset = 1'b0;
  logic              pwen = 1'b1;
  wire logic         line;
  logic              oe, txv, txr, mission_active_flag, alarm_wait_flag, rd, scr, rwe, mwe, go, lo;
  logic [7:0]        txd, st;
  logic [15:0]       addr;
  logger_pkg::byte_t rx;
  int                n_mismatch = 0;
  int                num_checks = 0;
  int                n_go = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (go === 1'b1) n_go++;
  mission_stop_access_arbiter #(.LOW_STD_CYC(LOW)) mission_stop_access_arbiter_inst (
    .clk_i(clk), .srst_i(srst), .line_i(line), .line_o(lo), .line_oe_o(oe),
    .overdrive_i(1'b0), .rom_done_i(rom_done), .rx_i(rx), .drive_low_i(1'b0),
    .tx_valid_o(txv), .tx_data_o(txd), .tx_ready_i(txr), .sample_busy_i(busy),
    .mission_start_i(mstart), .alarm_wait_flag_set_i(wset), .alarm_wait_flag_clr_i(1'b0), .mip_o(mission_active_flag),
    .alarm_wait_flag_o(alarm_wait_flag), .status_o(st), .pw_en_i(pwen), .full_pw_i(PW), .read_pw_i(~PW),
    .auth_i(AUTH), .copy_reg_page_i(1'b0), .mem_addr_o(addr), .mem_rd_o(rd),
    .scr_sel_o(scr), .mem_rdata_i(addr[7:0]), .reg_wr_en_o(rwe), .mem_wr_en_o(mwe),
    .copy_go_o(go));
  bus_master_model bus_master_model_inst (.clk_i(clk), .line_oe_i(oe), .tx_valid_i(txv),
    .tx_data_i(txd), .line_o(line), .rx_o(rx), .tx_ready_o(txr));
  ////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic tx(input logic [7:0] b);
    bus_master_model_inst.send(b);
  endtask
  task automatic start(input logic [7:0] op);
    @(posedge clk);
    rom_done <= 1'b1;
    @(posedge clk);
    rom_done <= 1'b0;
    tx(op);
  endtask
  task automatic pw(input logic [63:0] p);
    for (int i = 0; i < 8; i++) tx(p[8*i +: 8]);
  endtask
  task automatic stop(input logic [63:0] p);
    start(logger_pkg::OP_STOP);
    pw(p);
    tx(logger_pkg::DUMMY_B);
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic copy();
    start(logger_pkg::OP_COPY);
    for (int i = 0; i < 3; i++) tx(AUTH[8*i +: 8]);
    pw(PW);
  endtask
  task automatic rst_bus();
    bus_master_model_inst.bus_reset(LOW + 8);
  endtask
  task automatic expect_byte(input string what, input logic [7:0] exp);
    logic [7:0] b;
    bit         ok;
    bus_master_model_inst.fetch(3, 200, b, ok);
    if (!ok) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen none", what, exp);
      tally_and_finish();
    end else
      chk(what, exp, b);
  endtask
  // a refused command must not hand out a single byte before the bus reset
  task automatic silent();
    logic [7:0] b;
    bit         ok;
    bus_master_model_inst.fetch(0, 40, b, ok);
    chk("reply", 8'h00, 8'(ok));
    rst_bus();
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk("mip", 8'h00, 8'(mission_active_flag));
    chk("reg_wr_en", 8'h01, 8'(rwe));
    stop(PW);
    silent();
    chk("mip", 8'h00, 8'(mission_active_flag));
    $display("test stop_without_mission done");
    @(posedge clk);
    mstart <= 1'b1;
    wset <= 1'b1;
    @(posedge clk);
    mstart <= 1'b0;
    wset <= 1'b0;
    @(posedge clk);
    #1;
    chk("status", ST, st);
    chk("reg_wr_en", 8'h00, 8'(rwe));
    stop(~PW);
    silent();
    chk("mip", 8'h01, 8'(mission_active_flag));
    $display("test wrong_password done");
    busy <= 1'b1;
    stop(PW);
    busy <= 1'b0;
    chk("mip", 8'h01, 8'(mission_active_flag));
    rst_bus();
    start(logger_pkg::OP_RDMEM);
    tx(8'h15);
    tx(8'h02);
    pw(PW);
    expect_byte("status", ST);
    rst_bus();
    $display("test interfered_stop done");
    busy <= 1'b1;
    start(logger_pkg::OP_RDMEM);
    tx(8'h10);
    tx(8'h00);
    pw(PW);
    for (int i = 0; i < 3; i++) expect_byte("data", 8'hff);
    busy <= 1'b0;
    rst_bus();
    busy <= 1'b1;
    copy();
    busy <= 1'b0;
    silent();
    chk("copies", 8'h00, 8'(n_go));
    $display("test interfered_access done");
    pwen <= 1'b0;
    stop(~PW);
    chk("mip", 8'h00, 8'(mission_active_flag));
    chk("alarm_wait_flag", 8'h01, 8'(alarm_wait_flag));
    chk("reg_wr_en", 8'h01, 8'(rwe));
    rst_bus();
    pwen <= 1'b1;
    copy();
    for (int i = 0; i < 2; i++) expect_byte("alt", logger_pkg::ALT_B);
    chk("copies", 8'h01, 8'(n_go));
    $display("test accepted_stop done");
    rst_bus();
    start(logger_pkg::OP_RDSCR);
    expect_byte("scratch", 8'h00);
    expect_byte("scratch", 8'h01);
    chk("scr_sel", 8'h01, 8'(scr));
    rst_bus();
    busy <= 1'b1;
    start(logger_pkg::OP_RDSCR);
    for (int i = 0; i < 2; i++) expect_byte("scratch", 8'hff);
    busy <= 1'b0;
    rst_bus();
    $display("test scratchpad_read done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
